// ==== logic/debug_link_pkg.sv ====
// Constants, register map and types of the single-pin debug serial link.
// Assumes one 100 MHz system clock and a plain register port.
package debug_link_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RELOAD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_TXDATA = 8'h0C;
  localparam logic [7:0] OFS_RXDATA = 8'h10;

  // Control register bit positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_LOCK = 1;
  localparam int CTRL_SYNC_CR = 2;
  localparam int CTRL_ARM = 3;
  localparam int CTRL_NINE = 4;
  localparam int CTRL_ABORT = 5;
  localparam int CTRL_FERR = 6;
  localparam int CTRL_COLL = 7;

  // Debug control register, bit 7 down to bit 0
  typedef struct packed {
    logic coll;
    logic ferr;
    logic abort_status;
    logic nine_bit;
    logic autobaud_arm;
    logic sync_cr;
    logic lock;
    logic enable;
  } ctrl_t;

  // Enable and auto-baud armed after reset
  localparam logic [7:0] CTRL_RESET = 8'h09;
  localparam logic [15:0] RELOAD_RESET = 16'h0040;
  localparam int RELOAD_EN_BITS = 12;
  localparam logic [15:0] BREAK_CLKS = 16'h1000;

  // Sync characters and rising edges that close their measurement
  localparam logic [7:0] SYNC_DEFAULT = 8'h80;
  localparam logic [7:0] SYNC_CR = 8'h0D;
  localparam logic [1:0] AB_RISES_DEFAULT = 2'h1;
  localparam logic [1:0] AB_RISES_CR = 2'h3;

  // Status register bit positions
  localparam int STAT_TX_BUSY = 0;
  localparam int STAT_RX_VALID = 1;
  localparam int STAT_BREAK = 2;
  localparam int STAT_AUTOBAUD = 3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX_START = 3'h1,
    ST_RX_DATA = 3'h3,
    ST_RX_STOP = 3'h2,
    ST_TX = 3'h6,
    ST_BREAK = 3'h7,
    ST_AUTOBAUD = 3'h5
  } link_state_t;

endpackage

// ==== logic/debug_serial_link.sv ====
// Single-pin half-duplex open-drain serial link with baud generator and auto-baud.
// Assumes the pin has an external pull-up and software uses the plain register port.
//
// Our own choices: the plain strobed port and the address map.
module debug_serial_link #(
  parameter logic [15:0] RELOAD_INIT = debug_link_pkg::RELOAD_RESET,
  parameter logic [15:0] BREAK_LEN = debug_link_pkg::BREAK_CLKS
) (
  input wire logic clk_i, // System clock
  input wire logic rstn_i, // Async reset, active low
  input wire logic [7:0] reg_addr_i, // Register byte address
  input wire logic [31:0] reg_wdata_i, // Write data
  input wire logic reg_wr_i, // Write strobe
  input wire logic reg_rd_i, // Read strobe
  output logic [31:0] reg_rdata_o, // Read data, cycle after strobe
  input wire logic debug_serial_pin_i, // Pin level
  output logic debug_serial_pin_do_o, // Pin output value, always low
  output logic debug_serial_pin_oe_o, // Pin pulled low while high
  output logic on_chip_debugger_en_o, // Debugger owns the pin
  output logic pin_free_o // Pin released for other use
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  debug_link_pkg::ctrl_t ctrl_r;
  debug_link_pkg::link_state_t st_r;
  logic [15:0] reload_r;
  logic [15:0] cnt_r;
  logic [15:0] ab_cnt_r;
  logic [1:0] ab_rise_r;
  logic [3:0] idx_r;
  logic [8:0] shift_r;
  logic [10:0] frame_r;
  logic [8:0] tx_data_r;
  logic tx_pend_r;
  logic [8:0] rx_data_r;
  logic rx_valid_r;
  logic [2:0] sync_r;
  logic line_r;
  logic line_q;
  logic fall;
  logic rise;
  logic tick;
  logic [15:0] eff_reload;
  logic [15:0] bit_cyc;
  logic [15:0] half_cyc;
  logic [3:0] nbits;
  logic rx_ok;
  logic rx_ferr;
  logic tx_coll;
  logic abort_go;
  logic tx_start;
  logic ab_done;
  logic [1:0] ab_target;
  logic ab_counting;
  logic wr_ctrl;
  logic [3:0] oe_dly_r;

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchroniser; level changes once second and third stages agree

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_r <= 3'h7;
    end else begin
      sync_r <= {sync_r[1:0], debug_serial_pin_i};
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      line_r <= 1'b1;
      line_q <= 1'b1;
    end else begin
      if (sync_r[1] == sync_r[2]) begin
        line_r <= sync_r[2];
      end
      line_q <= line_r;
    end
  end

  assign fall = line_q & ~line_r;
  assign rise = ~line_q & line_r;

  ////////////////////////////////////////////////////////////////////////////
  // Baud timing

  always_comb begin
    eff_reload = reload_r;
    if (ctrl_r.enable) begin
      eff_reload = {4'h0, reload_r[debug_link_pkg::RELOAD_EN_BITS-1:0]};
    end
    bit_cyc = eff_reload >> 3;
    half_cyc = eff_reload >> 4;
    if (bit_cyc == 16'h0) begin
      bit_cyc = 16'h1;
    end
    if (half_cyc == 16'h0) begin
      half_cyc = 16'h1;
    end
  end

  assign nbits = ctrl_r.nine_bit ? 4'h9 : 4'h8;
  assign tick = (cnt_r == 16'h1);

  ////////////////////////////////////////////////////////////////////////////
  // Link events

  assign rx_ok = (st_r == debug_link_pkg::ST_RX_STOP) && tick && line_r;
  assign rx_ferr = (st_r == debug_link_pkg::ST_RX_STOP) && tick && !line_r;
  // Released bit read back low at mid bit means another driver; drive is delayed to match input latency
  assign tx_coll = (st_r == debug_link_pkg::ST_TX) && (cnt_r == half_cyc) && !oe_dly_r[3] && !line_r;
  assign abort_go = (rx_ferr | tx_coll) & ctrl_r.enable;
  assign tx_start = (st_r == debug_link_pkg::ST_IDLE) && !fall && tx_pend_r;
  assign ab_target = ctrl_r.sync_cr ? debug_link_pkg::AB_RISES_CR : debug_link_pkg::AB_RISES_DEFAULT;
  assign ab_counting = !ctrl_r.sync_cr || (ab_rise_r != 2'h0);
  assign ab_done = (st_r == debug_link_pkg::ST_AUTOBAUD) && rise && (2'(ab_rise_r + 2'h1) == ab_target);
  assign wr_ctrl = reg_wr_i && (reg_addr_i == debug_link_pkg::OFS_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // Link state machine

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= debug_link_pkg::ST_IDLE;
      cnt_r <= 16'h0;
      idx_r <= 4'h0;
      shift_r <= 9'h0;
      frame_r <= 11'h7FF;
      ab_cnt_r <= 16'h0;
      ab_rise_r <= 2'h0;
    end else begin
      case (st_r)
        debug_link_pkg::ST_IDLE: begin
          if (fall && ctrl_r.autobaud_arm) begin
            st_r <= debug_link_pkg::ST_AUTOBAUD;
            ab_cnt_r <= 16'h0;
            ab_rise_r <= 2'h0;
          end else if (fall) begin
            st_r <= debug_link_pkg::ST_RX_START;
            cnt_r <= half_cyc;
          end else if (tx_start) begin
            st_r <= debug_link_pkg::ST_TX;
            cnt_r <= bit_cyc;
            idx_r <= 4'(nbits + 4'h1);
            if (ctrl_r.nine_bit) begin
              frame_r <= {1'b1, tx_data_r, 1'b0};
            end else begin
              frame_r <= {2'h3, tx_data_r[7:0], 1'b0};
            end
          end
        end
        debug_link_pkg::ST_RX_START: begin
          if (!tick) begin
            cnt_r <= 16'(cnt_r - 16'h1);
          end else if (line_r) begin
            st_r <= debug_link_pkg::ST_IDLE;
          end else begin
            st_r <= debug_link_pkg::ST_RX_DATA;
            cnt_r <= bit_cyc;
            idx_r <= 4'h0;
          end
        end
        debug_link_pkg::ST_RX_DATA: begin
          if (!tick) begin
            cnt_r <= 16'(cnt_r - 16'h1);
          end else begin
            shift_r <= {line_r, shift_r[8:1]};
            cnt_r <= bit_cyc;
            idx_r <= 4'(idx_r + 4'h1);
            if (idx_r == 4'(nbits - 4'h1)) begin
              st_r <= debug_link_pkg::ST_RX_STOP;
            end
          end
        end
        debug_link_pkg::ST_RX_STOP: begin
          if (!tick) begin
            cnt_r <= 16'(cnt_r - 16'h1);
          end else if (abort_go) begin
            st_r <= debug_link_pkg::ST_BREAK;
            cnt_r <= BREAK_LEN;
          end else begin
            st_r <= debug_link_pkg::ST_IDLE;
          end
        end
        debug_link_pkg::ST_TX: begin
          if (abort_go) begin
            st_r <= debug_link_pkg::ST_BREAK;
            cnt_r <= BREAK_LEN;
          end else if (!tick) begin
            cnt_r <= 16'(cnt_r - 16'h1);
          end else if (idx_r == 4'h0) begin
            st_r <= debug_link_pkg::ST_IDLE;
          end else begin
            frame_r <= {1'b1, frame_r[10:1]};
            idx_r <= 4'(idx_r - 4'h1);
            cnt_r <= bit_cyc;
          end
        end
        debug_link_pkg::ST_BREAK: begin
          if (!tick) begin
            cnt_r <= 16'(cnt_r - 16'h1);
          end else begin
            st_r <= debug_link_pkg::ST_IDLE;
          end
        end
        debug_link_pkg::ST_AUTOBAUD: begin
          if (ab_counting) begin
            ab_cnt_r <= 16'(ab_cnt_r + 16'h1);
          end
          if (rise) begin
            ab_rise_r <= 2'(ab_rise_r + 2'h1);
          end
          if (ab_done || ab_cnt_r == 16'hFFFF) begin
            st_r <= debug_link_pkg::ST_IDLE;
          end
        end
        default: begin
          st_r <= debug_link_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive: open drain, pulled low only

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      debug_serial_pin_oe_o <= 1'b0;
      debug_serial_pin_do_o <= 1'b0;
      oe_dly_r <= 4'h0;
    end else begin
      oe_dly_r <= {oe_dly_r[2:0], debug_serial_pin_oe_o};
      debug_serial_pin_do_o <= 1'b0;
      debug_serial_pin_oe_o <= ((st_r == debug_link_pkg::ST_TX) && !frame_r[0])
                               || (st_r == debug_link_pkg::ST_BREAK);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_r <= debug_link_pkg::CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_r.enable <= reg_wdata_i[debug_link_pkg::CTRL_EN] | ctrl_r.lock;
        ctrl_r.lock <= ctrl_r.lock | reg_wdata_i[debug_link_pkg::CTRL_LOCK];
        if (!ctrl_r.enable) begin
          ctrl_r.sync_cr <= reg_wdata_i[debug_link_pkg::CTRL_SYNC_CR];
        end
        ctrl_r.nine_bit <= reg_wdata_i[debug_link_pkg::CTRL_NINE];
      end
      if (ab_done) begin
        ctrl_r.autobaud_arm <= 1'b0;
      end else if (wr_ctrl) begin
        ctrl_r.autobaud_arm <= reg_wdata_i[debug_link_pkg::CTRL_ARM];
      end
      // Sticky flags: hardware set wins over a write-one clear
      ctrl_r.abort_status <= abort_go
        | (ctrl_r.abort_status & ~(wr_ctrl & reg_wdata_i[debug_link_pkg::CTRL_ABORT]));
      ctrl_r.ferr <= rx_ferr | (ctrl_r.ferr & ~(wr_ctrl & reg_wdata_i[debug_link_pkg::CTRL_FERR]));
      ctrl_r.coll <= tx_coll | (ctrl_r.coll & ~(wr_ctrl & reg_wdata_i[debug_link_pkg::CTRL_COLL]));
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      on_chip_debugger_en_o <= 1'b1;
      pin_free_o <= 1'b0;
    end else begin
      on_chip_debugger_en_o <= ctrl_r.enable;
      pin_free_o <= !ctrl_r.enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud reload register

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reload_r <= RELOAD_INIT;
    end else if (ab_done) begin
      reload_r <= 16'(ab_cnt_r + 16'h1);
    end else if (reg_wr_i && reg_addr_i == debug_link_pkg::OFS_RELOAD) begin
      reload_r <= reg_wdata_i[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit and receive data

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_data_r <= 9'h0;
      tx_pend_r <= 1'b0;
    end else begin
      if (tx_start || abort_go) begin
        tx_pend_r <= 1'b0;
      end else if (reg_wr_i && reg_addr_i == debug_link_pkg::OFS_TXDATA && !tx_pend_r
                   && st_r != debug_link_pkg::ST_TX) begin
        tx_pend_r <= 1'b1;
        tx_data_r <= reg_wdata_i[8:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_data_r <= 9'h0;
      rx_valid_r <= 1'b0;
    end else if (rx_ok) begin
      rx_valid_r <= 1'b1;
      rx_data_r <= ctrl_r.nine_bit ? shift_r : {1'b0, shift_r[8:1]};
    end else if (reg_rd_i && reg_addr_i == debug_link_pkg::OFS_RXDATA) begin
      rx_valid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 32'h0;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_addr_i == debug_link_pkg::OFS_CTRL) begin
      reg_rdata_o <= {24'h0, ctrl_r};
    end else if (reg_addr_i == debug_link_pkg::OFS_RELOAD) begin
      reg_rdata_o <= {16'h0, reload_r};
    end else if (reg_addr_i == debug_link_pkg::OFS_STATUS) begin
      reg_rdata_o <= {28'h0, st_r == debug_link_pkg::ST_AUTOBAUD, st_r == debug_link_pkg::ST_BREAK,
                      rx_valid_r, tx_pend_r | (st_r == debug_link_pkg::ST_TX)};
    end else if (reg_addr_i == debug_link_pkg::OFS_RXDATA) begin
      reg_rdata_o <= {23'h0, rx_data_r};
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_lock_holds_enable: assert property (
    wr_ctrl && ctrl_r.lock |=> ctrl_r.enable)
    else $error("enable cleared while locked");

  a_pin_open_drain: assert property (
    debug_serial_pin_do_o == 1'b0)
    else $error("pin driven high");

  a_half_duplex: assert property (
    st_r == debug_link_pkg::ST_TX && !abort_go |=> st_r inside {debug_link_pkg::ST_TX, debug_link_pkg::ST_IDLE})
    else $error("receive entered during transmit");

  a_tx_start_low: assert property (
    st_r == debug_link_pkg::ST_IDLE && tx_start |=> ##1 debug_serial_pin_oe_o)
    else $error("start bit not driven low");

  a_false_start: assert property (
    st_r == debug_link_pkg::ST_RX_START && tick && line_r |=> st_r == debug_link_pkg::ST_IDLE)
    else $error("false start not ignored");

  a_data_spacing: assert property (
    st_r == debug_link_pkg::ST_RX_START && tick && !line_r |=> cnt_r == $past(bit_cyc))
    else $error("data sample not one bit after start centre");

  a_frame_error: assert property (
    rx_ferr |=> ctrl_r.ferr && !rx_valid_r || $past(rx_valid_r))
    else $error("framing error not flagged");

  a_stop_resume: assert property (
    rx_ok |=> st_r == debug_link_pkg::ST_IDLE)
    else $error("receiver waited past stop centre");

  a_break_length: assert property (
    abort_go |=> st_r == debug_link_pkg::ST_BREAK && cnt_r == BREAK_LEN ##1 debug_serial_pin_oe_o)
    else $error("break not started after error");

  a_autobaud_load: assert property (
    ab_done |=> reload_r == 16'($past(ab_cnt_r) + 16'h1) && !ctrl_r.autobaud_arm)
    else $error("measured count not loaded");

  a_sync_select: assert property (
    ctrl_r.enable |=> $stable(ctrl_r.sync_cr))
    else $error("sync character changed while enabled");

  c_rx_char: cover property (rx_ok);
  c_autobaud: cover property (ab_done);
  c_break: cover property (abort_go);
  c_tx_char: cover property (st_r == debug_link_pkg::ST_TX ##1 st_r == debug_link_pkg::ST_IDLE);

endmodule

// ==== tb/host_port.sv ====
// Host serial port model at the far side of the single-pin debug link.
// Assumes the bench resolves the open-drain wire from both pull-low enables.
module host_port (
  input wire logic clk_i, // System clock
  input wire logic line_i, // Resolved pin level
  output logic pull_low_o // Host pulls the line low
);
  timeunit 1ns;
  timeprecision 1ps;

  initial pull_low_o = 1'b0;

  // Start, eight data bits LSB first, stop; the stop may be short or held low
  task automatic send(input logic [7:0] d, input int per, input logic stop_hi, input int stop_cyc);
    logic [9:0] f;
    f = {stop_hi, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      pull_low_o <= ~f[i];
      repeat ((i == 9) ? stop_cyc : per) @(posedge clk_i);
    end
    // A high stop already released the line, so a back-to-back call may pull it at once
    if (!stop_hi) begin
      pull_low_o <= 1'b0;
    end
  endtask

  // Short low pulse that must not pass as a start bit
  task automatic glitch(input int n);
    pull_low_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    pull_low_o <= 1'b0;
  endtask

  // Receives only while not sending: the line is half duplex
  task automatic recv(input int per, output logic [7:0] d, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    d = 8'h00;
    while (line_i !== 1'b0 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (n < 3000) begin
      repeat (per / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (per) @(posedge clk_i);
        d[i] = line_i;
      end
      repeat (per) @(posedge clk_i);
      ok = line_i;
    end
  endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench of the single-pin debug serial link.
// Assumes the host model drives the far side and a pull-up holds the idle line high.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] rdata;
  logic pin_do, pin_oe, dbg_en, pin_free, host_low, line;
  int failures = 0;
  int compares = 0;
  int cycles = 0;

  assign line = (pin_oe ? pin_do : 1'b1) & ~host_low;

  debug_serial_link #(.BREAK_LEN(16'h0010)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .debug_serial_pin_i(line),
    .debug_serial_pin_do_o(pin_do), .debug_serial_pin_oe_o(pin_oe),
    .on_chip_debugger_en_o(dbg_en), .pin_free_o(pin_free)
  );

  host_port host (.clk_i(clk_i), .line_i(line), .pull_low_o(host_low));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (failures == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 50000) begin
      failures++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_i);
    reg_wr <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_i);
    reg_rd <= 1'b0;
    @(negedge clk_i);
    d = rdata;
    @(posedge clk_i);
  endtask

  // Reload that spans eight bit periods
  function automatic int reload_of(input int per);
    return per * 8;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic [7:0] d, got;
    logic ok;
    int n, m;
    void'($urandom(32'h9f34));
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk({31'h0, dbg_en}, 32'h1);
    chk({31'h0, pin_free}, 32'h0);
    rd(debug_link_pkg::OFS_CTRL, r);
    chk(r, 32'h00000009);
    // Auto-baud on the default sync character at ten clocks per bit
    host.send(8'h80, 10, 1'b1, 10);
    repeat (20) @(posedge clk_i);
    rd(debug_link_pkg::OFS_RELOAD, r);
    n = reload_of(10);
    chk({31'h0, (int'(r) >= n - 1) && (int'(r) <= n + 1)}, 32'h1);
    rd(debug_link_pkg::OFS_CTRL, r);
    chk({31'h0, r[debug_link_pkg::CTRL_ARM]}, 32'h0);
    wr(debug_link_pkg::OFS_RELOAD, 32'h00000050);
    // False start, then back-to-back characters with shortened stop bits
    host.glitch(2);
    repeat (30) @(posedge clk_i);
    for (int k = 0; k < 3; k++) begin
      d = 8'($urandom);
      host.send(d, 10, 1'b1, 7);
      fork
        host.send(~d, 10, 1'b1, 10);
        begin
          // First character lands at its stop centre, a few cycles into the next one
          repeat (5) @(posedge clk_i);
          rd(debug_link_pkg::OFS_RXDATA, r);
          chk(r & 32'hFF, {24'h0, d});
        end
      join
      repeat (3) @(posedge clk_i);
      rd(debug_link_pkg::OFS_RXDATA, r);
      chk(r & 32'hFF, {24'h0, ~d});
    end
    // Transmit at the 0x50 rate written after auto-baud and at a software rate with high bits set
    for (int k = 0; k < 4; k++) begin
      if (k == 2) begin
        wr(debug_link_pkg::OFS_RELOAD, 32'h0000F060);
        rd(debug_link_pkg::OFS_RELOAD, r);
        chk(r, 32'h0000F060);
      end
      d = (k == 0) ? 8'h00 : 8'($urandom);
      wr(debug_link_pkg::OFS_TXDATA, {24'h0, d});
      host.recv((k < 2) ? 10 : 12, got, ok);
      chk({24'h0, got}, {24'h0, d});
      chk({31'h0, ok}, 32'h1);
      repeat (10) @(posedge clk_i);
    end
    // Low stop bit while enabled: framing error, abort and break
    fork
      host.send(8'($urandom), 12, 1'b0, 12);
      begin
        n = 0;
        m = 0;
        while (pin_oe !== 1'b1 && n < 400) begin
          @(negedge clk_i);
          n++;
        end
        while (pin_oe === 1'b1 && m < 100) begin
          @(negedge clk_i);
          m++;
        end
      end
    join
    chk(m, 32'h10);
    @(posedge clk_i);
    rd(debug_link_pkg::OFS_CTRL, r);
    chk(r & 32'h60, 32'h60);
    wr(debug_link_pkg::OFS_CTRL, 32'h00000061);
    rd(debug_link_pkg::OFS_CTRL, r);
    chk(r & 32'h60, 32'h0);
    // Host pulls the line low under released data bits: collision, abort and break
    wr(debug_link_pkg::OFS_TXDATA, 32'h000000FF);
    repeat (20) @(posedge clk_i);
    host.glitch(20);
    repeat (40) @(posedge clk_i);
    rd(debug_link_pkg::OFS_CTRL, r);
    chk(r & 32'hA0, 32'hA0);
    wr(debug_link_pkg::OFS_CTRL, 32'h000000A1);
    // Nine data bits: the host's high stop arrives as the ninth bit
    wr(debug_link_pkg::OFS_CTRL, 32'h00000011);
    d = 8'($urandom);
    host.send(d, 12, 1'b1, 12);
    repeat (20) @(posedge clk_i);
    rd(debug_link_pkg::OFS_RXDATA, r);
    chk(r, {23'h0, 1'b1, d});
    // Sync character choice, disable, lock
    wr(debug_link_pkg::OFS_CTRL, 32'h00000005);
    rd(debug_link_pkg::OFS_CTRL, r);
    chk({31'h0, r[debug_link_pkg::CTRL_SYNC_CR]}, 32'h0);
    wr(debug_link_pkg::OFS_CTRL, 32'h00000000);
    repeat (2) @(posedge clk_i);
    chk({30'h0, dbg_en, pin_free}, 32'h1);
    wr(debug_link_pkg::OFS_CTRL, 32'h00000004);
    rd(debug_link_pkg::OFS_CTRL, r);
    chk({31'h0, r[debug_link_pkg::CTRL_SYNC_CR]}, 32'h1);
    // Auto-baud on the carriage-return character while the debugger is off
    wr(debug_link_pkg::OFS_CTRL, 32'h0000000C);
    host.send(debug_link_pkg::SYNC_CR, 10, 1'b1, 10);
    repeat (20) @(posedge clk_i);
    rd(debug_link_pkg::OFS_RELOAD, r);
    n = reload_of(10);
    chk({31'h0, (int'(r) >= n - 1) && (int'(r) <= n + 1)}, 32'h1);
    wr(debug_link_pkg::OFS_CTRL, 32'h00000003);
    wr(debug_link_pkg::OFS_CTRL, 32'h00000002);
    repeat (2) @(posedge clk_i);
    rd(debug_link_pkg::OFS_CTRL, r);
    chk({31'h0, r[debug_link_pkg::CTRL_EN]}, 32'h1);
    chk({30'h0, dbg_en, pin_free}, 32'h2);
    rd(8'h20, r);
    chk(r, 32'h0);
    close_out();
  end
endmodule
